/* File: core/src_sync.sv */
// Two-flop synchroniser for a vector of level inputs.
// Assumes inputs are asynchronous levels from the framer cores.
`timescale 1ns/10ps
module src_sync
   import vec_mask_pkg::*;
#(
   parameter int WIDTH = 16
)
(
   // Clock and reset
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             clk_en,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   // First stage is read only by the second stage
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         meta_reg <= '0;
         sync_out <= '0;
      end
      else if (clk_en)
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

/* File: core/upper_framer_irq_vector_mask.sv */
// Upper-framer interrupt vector mask with AHB-Lite register slave.
// Assumes one AHB-Lite master, single word transfers, one clock hclk.
// Source inputs are asynchronous levels, already ORed per source register.
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "vec_mask_defs.svh"
module upper_framer_irq_vector_mask
   import vec_mask_pkg::*;
(
   // Clock, reset, enable
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire logic          clk_en,
   // AHB-Lite slave
   input  wire logic          hsel,
   input  wire logic [31:0]   haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output logic      [31:0]   hrdata,
   output logic               hreadyout,
   output logic               hresp,
   // Framer source levels, framers seven down to four
   input  wire upper_src_type src_any,
   // Vector flags out
   output logic      [3:0]    hdlc_vector,
   output logic      [11:0]   other_vector,
   // Interrupt
   output logic               irq
);

   upper_src_type src_sync_w;
   upper_src_type flags_w;
   upper_src_type mask_reg;
   logic [15:0]   irq_status_reg;
   logic [15:0]   irq_mask_reg;
   upper_src_type flags_prev_reg;
   ahb_req_type   req_reg;
   bus_state_type state_reg;
   logic          wr_mask;
   logic          wr_status;
   logic          wr_imask;
   logic [15:0]   rise_w;
   logic [15:0]   rd_word;

   // Picks the HDLC bit of each framer nibble into a 4-bit vector
   function automatic logic [3:0] hdlc_of(input upper_src_type v);
      logic [3:0] r;
      r = '0;
      for (int i = 0; i < 4; i++)
         r[i] = v[i].hdlc;
      return r;
   endfunction

   // Packs the three non-HDLC bits of each framer, framer seven on top
   function automatic logic [11:0] other_of(input upper_src_type v);
      logic [11:0] r;
      r = '0;
      for (int i = 0; i < 4; i++)
         r[i*3 +: 3] = {v[i].elastic, v[i].rxline, v[i].sync_ovf};
      return r;
   endfunction

   // Decodes a captured write request against a register index
   function automatic logic wr_hit(input ahb_req_type q,
                                   input logic [11:0] idx);
      return q.valid && q.write && (q.index == idx);
   endfunction

   src_sync #(
      .WIDTH    (16)
   ) u_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .clk_en   (clk_en),
      .async_in (src_any),
      .sync_out (src_sync_w)
   );

   vector_gate u_gate (
      .src_any (src_sync_w),
      .mask    (mask_reg),
      .flags   (flags_w)
   );

   // Data phase write strobes
   assign wr_mask   = wr_hit(req_reg, `IDX_VECTOR_MASK); // [RULE8]
   assign wr_status = wr_hit(req_reg, `IDX_IRQ_STATUS);
   assign wr_imask  = wr_hit(req_reg, `IDX_IRQ_MASK);

   // Rising vector flags are the events that set sticky status
   assign rise_w = flags_w & ~flags_prev_reg;

   // Bus state: address phase captured when hready and selected
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         req_reg   <= '0;
         state_reg <= st_idle;
      end
      else if (clk_en)
      begin
         if (hready)
         begin
            req_reg.valid <= hsel && htrans[1];
            req_reg.write <= hwrite;
            // Index is word address; byte bits are ignored
            req_reg.index <= haddr[13:2];
            state_reg     <= (hsel && htrans[1]) ? st_data : st_idle;
         end
      end
   end

   // Slave never inserts wait states and never errors
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else if (clk_en)
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // Mask register, framer seven in the top nibble
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         mask_reg <= `RST_VECTOR_MASK; // [RULE10]
      else if (clk_en && wr_mask)
         mask_reg <= hwdata[15:0]; // [RULE3] [RULE4] [RULE5] [RULE6]
   end

   // Interrupt mask register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq_mask_reg <= `RST_IRQ_MASK;
      else if (clk_en && wr_imask)
         irq_mask_reg <= hwdata[15:0];
   end

   // Sticky status: a new event wins over a write-one clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_status_reg <= `RST_IRQ_STATUS;
         flags_prev_reg <= '0;
      end
      else if (clk_en)
      begin
         flags_prev_reg <= flags_w;
         irq_status_reg <= (irq_status_reg
                            & ~(wr_status ? hwdata[15:0] : 16'h0000))
                           | rise_w;
      end
   end

   // Registered vector outputs, split by target vector register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hdlc_vector  <= '0;
         other_vector <= '0;
      end
      else if (clk_en)
      begin
         hdlc_vector  <= hdlc_of(flags_w);  // [RULE7]
         other_vector <= other_of(flags_w); // [RULE7]
      end
   end

   // Level interrupt from unmasked sticky bits; irq mask one enables
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq <= 1'b0;
      else if (clk_en)
         irq <= |((irq_status_reg | rise_w) & irq_mask_reg
                  & ~(wr_status ? hwdata[15:0] & ~rise_w : 16'h0000));
   end

   // Read mux in the address phase; unmapped reads return zero
   always_comb
   begin
      rd_word = 16'h0000;
      unique case (haddr[13:2])
         `IDX_VECTOR_MASK:  rd_word = mask_reg;
         `IDX_VECTOR_HDLC:  rd_word = {12'h000, hdlc_of(flags_w)};
         `IDX_VECTOR_OTHER: rd_word = {4'h0, other_of(flags_w)};
         `IDX_IRQ_STATUS:   rd_word = irq_status_reg;
         `IDX_IRQ_MASK:     rd_word = irq_mask_reg;
         `IDX_SRC_LEVEL:    rd_word = src_sync_w;
         default:           rd_word = 16'h0000;
      endcase
   end

   // Read data registered so it stands in the data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= '0;
      else if (clk_en && hready && hsel && htrans[1] && !hwrite)
         hrdata <= {16'h0000, rd_word}; // [RULE8]
   end

endmodule

/* File: core/vector_gate.sv */
// Gates framer source levels with their mask bits into vector flags.
// Assumes synchronised source levels and the mask word on the same clock.
`timescale 1ns/10ps
module vector_gate
   import vec_mask_pkg::*;
(
   // Inputs
   input  wire upper_src_type src_any,
   input  wire upper_src_type mask,
   // Vector flags
   output upper_src_type      flags
);

   // A set mask forces its flag low; a clear one passes the source
   assign flags = src_any & ~mask; // [RULE1] [RULE2] [RULE9]

endmodule

/* File: include/vec_mask_defs.svh */
// Constants for the upper-framer vector mask block: offsets, fields, resets.
// Assumes inclusion by bare name from include/; definitions only.
//
// Functional notes
// [RULE1] Set mask bit forces its vector flag to zero
// [RULE2] Clear mask bit lets flag follow sources
// [RULE3] Bits 15..12: framer seven H,E,R,S masks
// [RULE4] Bits 11..8: framer six H,E,R,S masks
// [RULE5] Bits 7..4: framer five H,E,R,S masks
// [RULE6] Bits 3..0: framer four H,E,R,S masks
// [RULE7] HDLC masks gate 910; others gate 911
// [RULE8] Mask register at 903 is read/write
// [RULE9] Unmasked flag set when any source bit set
// [RULE10] Reset clears all mask bits
`ifndef VEC_MASK_DEFS_SVH
`define VEC_MASK_DEFS_SVH

// Printed offsets are register indices; byte address is four times these
`define IDX_VECTOR_MASK      12'h903
`define IDX_VECTOR_HDLC      12'h910
`define IDX_VECTOR_OTHER     12'h911
`define IDX_IRQ_STATUS       12'h920
`define IDX_IRQ_MASK         12'h921
`define IDX_SRC_LEVEL        12'h922

// Field positions inside a framer nibble, framer n at bits 4n-16+3..
`define FLD_HDLC             3
`define FLD_ELASTIC          2
`define FLD_RXLINE           1
`define FLD_SYNC_OVF         0
`define FRAMER_BASE          4

// Reset values
`define RST_VECTOR_MASK      16'h0000
`define RST_IRQ_MASK         16'h0000
`define RST_IRQ_STATUS       16'h0000

`endif

/* File: include/vec_mask_pkg.sv */
// Types shared by the vector mask block.
// Assumes nothing beyond a SystemVerilog compiler.
package vec_mask_pkg;

   // One framer's four source classes, HDLC in the top bit
   typedef struct packed {
      logic hdlc;
      logic elastic;
      logic rxline;
      logic sync_ovf;
   } framer_src_type;

   // Framers seven down to four in one word
   typedef framer_src_type [3:0] upper_src_type;

   // AHB-Lite address phase captured for the data phase
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [11:0] index;
   } ahb_req_type;

   typedef enum logic [1:0] {
      st_idle = 2'b01,
      st_data = 2'b10
   } bus_state_type;

endpackage

/* File: tb/testbench.sv */
// Self-checking bench for the vector mask block over AHB-Lite.
// Assumes one slave, so its hreadyout is the bus hready.
`timescale 1ns/10ps
`include "vec_mask_defs.svh"
module testbench
   import vec_mask_pkg::*;
   ;
   logic          hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
   logic [31:0]   haddr, hwdata, hrdata, rd;
   logic [1:0]    htrans;
   logic [2:0]    hsize;
   logic [3:0]    hdlc_vector;
   logic [11:0]   other_vector;
   upper_src_type src_any;
   int            err_total, check_count;
   assign hready = hreadyout;
   // Enable tied high: freezing is not exercised here
   upper_framer_irq_vector_mask u_upper_framer_irq_vector_mask (.hclk,
      .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hrdata, .hreadyout, .hresp, .src_any,
      .hdlc_vector, .other_vector, .irq);
   initial
   begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
   begin
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   end
   endtask
   task automatic conclude();
   begin
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
   endtask
   // One single transfer; waits on hready, never on a fixed count
   task automatic bus(input logic wr, input logic [11:0] idx,
                      input logic [31:0] wd);
   begin
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {18'h0, idx, 2'b00};
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   end
   endtask
   // Expected flag words from the source/mask product
   function automatic logic [31:0] hv(input logic [15:0] f);
      hv = {28'h0, f[15], f[11], f[7], f[3]};
   endfunction
   function automatic logic [31:0] ov(input logic [15:0] f);
      ov = {20'h0, f[14:12], f[10:8], f[6:4], f[2:0]};
   endfunction
   // Waits out the three-edge flag latency, samples off the edge
   task automatic vec_check(input logic [15:0] f);
   begin
      repeat (4) @(posedge hclk);
      #1;
      check({28'h0, hdlc_vector}, hv(f));
      check({20'h0, other_vector}, ov(f));
      @(posedge hclk);
   end
   endtask
   task automatic irq_check(input logic exp);
   begin
      repeat (3) @(posedge hclk);
      #1;
      check({31'h0, irq}, {31'h0, exp});
      @(posedge hclk);
   end
   endtask
   initial
   begin
      {hresetn, hsel, htrans, hwrite, haddr, hwdata} = '0;
      hsize = 3'b010;
      src_any = '0;
      err_total = 0;
      check_count = 0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b0, `IDX_VECTOR_MASK, 32'h0);
      check(rd, 32'h0);
      bus(1'b1, `IDX_VECTOR_MASK, 32'hffff_a5c3);
      bus(1'b0, `IDX_VECTOR_MASK, 32'h0);
      check(rd, 32'h0000_a5c3);
      bus(1'b0, 12'h905, 32'h0);
      check(rd, 32'h0);
      // Each source alone, unmasked then under its own mask bit
      for (int b = 0; b < 16; b++)
      begin
         src_any <= upper_src_type'(16'h1 << b);
         bus(1'b1, `IDX_VECTOR_MASK, 32'h0);
         vec_check(16'h1 << b);
         bus(1'b1, `IDX_VECTOR_MASK, 32'h1 << b);
         vec_check(16'h0);
      end
      // All sources on: one mask bit must hide exactly one flag
      src_any <= upper_src_type'(16'hffff);
      for (int b = 0; b < 16; b++)
      begin
         bus(1'b1, `IDX_VECTOR_MASK, 32'h1 << b);
         vec_check(~(16'h1 << b));
      end
      bus(1'b1, `IDX_VECTOR_MASK, 32'h8421);
      bus(1'b0, `IDX_VECTOR_HDLC, 32'h0);
      check(rd, hv(16'h7bde));
      bus(1'b0, `IDX_VECTOR_OTHER, 32'h0);
      check(rd, ov(16'h7bde));
      // Event held pending while disabled, raised once enabled, cleared
      src_any <= '0;
      bus(1'b1, `IDX_VECTOR_MASK, 32'h0);
      vec_check(16'h0);
      bus(1'b1, `IDX_IRQ_STATUS, 32'hffff);
      src_any <= upper_src_type'(16'h1);
      irq_check(1'b0);
      bus(1'b0, `IDX_IRQ_STATUS, 32'h0);
      check(rd, 32'h1);
      bus(1'b1, `IDX_IRQ_MASK, 32'h1);
      irq_check(1'b1);
      bus(1'b1, `IDX_IRQ_STATUS, 32'h1);
      irq_check(1'b0);
      conclude();
   end
   // Run needs well under a thousand cycles
   initial
   begin
      #200000;
      err_total++;
      conclude();
   end
endmodule

/* File: tb/vec_mask_assertions.sv */
// Port checker for the upper-framer vector mask block.
// Assumes one clock hclk and hready tied to hreadyout by the bench.
`timescale 1ns/10ps
`include "vec_mask_defs.svh"
module vec_mask_assertions
   import vec_mask_pkg::*;
(
   // Clock, reset, enable
   input wire logic          hclk,
   input wire logic          hresetn,
   input wire logic          clk_en,
   // Bus
   input wire logic          hsel,
   input wire logic [31:0]   haddr,
   input wire logic [1:0]    htrans,
   input wire logic          hwrite,
   input wire logic [2:0]    hsize,
   input wire logic [31:0]   hwdata,
   input wire logic          hready,
   input wire logic [31:0]   hrdata,
   input wire logic          hreadyout,
   input wire logic          hresp,
   // Sources and flags
   input wire upper_src_type src_any,
   input wire logic [3:0]    hdlc_vector,
   input wire logic [11:0]   other_vector,
   input wire logic          irq
);
   logic        rd_take;
   logic [3:0]  src_h;
   logic [11:0] src_o;
   // Read accepted in its address phase
   assign rd_take = hsel && htrans[1] && !hwrite && hready && clk_en;
   // Sources regrouped as the flag outputs are laid out
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         src_h[i] = src_any[i].hdlc;
         src_o[3*i +: 3] = {src_any[i].elastic, src_any[i].rxline,
                            src_any[i].sync_ovf};
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ready_always_a: assert property (hreadyout)
      else $error("hreadyout dropped");
   resp_okay_a: assert property (!hresp)
      else $error("hresp not okay");
   // Flags trail the sources by two sync flops and the output register
   hdlc_src_a: assert property ((hdlc_vector & ~$past(src_h, 3)) == 4'h0)
      else $error("hdlc flag without source");
   other_src_a: assert property ((other_vector & ~$past(src_o, 3)) == 12'h0)
      else $error("other flag without source");
   upper_zero_a: assert property (hrdata[31:16] == 16'h0)
      else $error("upper read half not zero");
   rdata_hold_a: assert property (!$past(rd_take) |-> $stable(hrdata))
      else $error("read data moved without a read");
   hdlc_read_a: assert property (rd_take && haddr[13:2] == `IDX_VECTOR_HDLC
      |=> hrdata == {28'h0, $past(hdlc_vector)}) else $error("hdlc read");
   other_read_a: assert property (rd_take && haddr[13:2] == `IDX_VECTOR_OTHER
      |=> hrdata == {20'h0, $past(other_vector)}) else $error("other read");
   unmapped_read_a: assert property (rd_take && haddr[13:2] == 12'h905
      |=> hrdata == 32'h0) else $error("unmapped read not zero");
   cover property (rd_take && haddr[13:2] == `IDX_VECTOR_MASK);
   cover property ($rose(irq));
   cover property (hdlc_vector != 4'h0 && other_vector != 12'h0);
endmodule
bind upper_framer_irq_vector_mask vec_mask_assertions u_chk (.hclk, .hresetn,
   .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
   .hrdata, .hreadyout, .hresp, .src_any, .hdlc_vector, .other_vector, .irq);
